// ==== alt_reset_pulser.sv ====
// one-shot delayed low pulse for the alternate cpu reset
`default_nettype none
`include "kbc_consts.svh"
module alt_reset_pulser
  import kbc_pkg::*;
#(
  parameter int DELAY_CYCLES = `ALT_DELAY_CYCLES,
  parameter int PULSE_CYCLES = `ALT_PULSE_CYCLES
) (
  input  wire logic clock_in,
  input  wire logic reset_in,
  input  wire logic arm_in,
  output var  logic alt_cpu_reset_n_out
);

  alt_state_t  state;
  logic [15:0] count;

  // ==========================================
  // sequencer: wait, pulse, then hold until disarmed
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state <= alt_idle;
      count <= 16'h0000;
    end else begin
      unique case (state)
        alt_idle: begin
          count <= 16'h0000;
          if (arm_in) begin
            state <= alt_delay;
          end
        end
        alt_delay: begin
          count <= count + 16'h0001;
          if (count == 16'(DELAY_CYCLES - 1)) begin
            state <= alt_pulse;
            count <= 16'h0000;
          end
        end
        alt_pulse: begin
          count <= count + 16'h0001;
          if (count == 16'(PULSE_CYCLES - 1)) begin
            state <= alt_spent;
          end
        end
        alt_spent: begin
          if (!arm_in) begin // R13
            state <= alt_idle;
          end
        end
      endcase
    end
  end

  // low only while pulsing
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      alt_cpu_reset_n_out <= 1'b1; // R14
    end else begin
      alt_cpu_reset_n_out <= !(state == alt_delay && count == 16'(DELAY_CYCLES - 1))
                             && !(state == alt_pulse && count != 16'(PULSE_CYCLES - 1)); // R12
    end
  end

endmodule
`default_nettype wire

// ==== host_model.sv ====
// host processor model issuing one-cycle i/o strobes
`default_nettype none
module host_model
  import kbc_pkg::*;
(
  input  wire logic      clock_in,
  output var  host_req_t host_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial host_out = '0;
  // strobe for one cycle, then scramble the released bus
  task automatic io(input logic rd, input logic [15:0] a, input logic [7:0] d);
    @(negedge clock_in);
    host_out <= '{rd, !rd, a, d};
    @(negedge clock_in);
    host_out <= '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// ==== kbc_consts.svh ====
// constants for the keyboard-controller status and fast gate/reset block
`ifndef KBC_CONSTS_SVH
`define KBC_CONSTS_SVH

// ==========================================
// host i/o addresses
`define KBC_DATA_ADDR      16'h0060
`define KBC_CMD_ADDR       16'h0064
`define FAST_PORT_ADDR     16'h0092
`define HOST_ADDR_BIT2_POS 2

// ==========================================
// status register fields and reset
`define STAT_CMD_POS       3
`define STAT_IN_FULL_POS   1
`define STAT_OUT_FULL_POS  0
`define STAT_RESET         8'h00

// ==========================================
// fast port fields and reset
`define FAST_RESET         8'h24
`define FAST_READ_MASK     8'h03
`define FAST_READ_FIXED    8'h24
`define FAST_GATE_POS      1
`define FAST_RST_POS       0
`define FAST_EN_POS        2

// ==========================================
// timing of the alternate reset pulse
`define CLOCK_NS           40
`define ALT_DELAY_NS       14000
`define ALT_PULSE_NS       6000
`define ALT_DELAY_CYCLES   ((`ALT_DELAY_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define ALT_PULSE_CYCLES   ((`ALT_PULSE_NS + `CLOCK_NS - 1) / `CLOCK_NS)

`endif

// ==== kbc_monitor.sv ====
// checker for the status flags and fast gate/reset port
`default_nettype none
`include "kbc_consts.svh"
module kbc_monitor
  import kbc_pkg::*;
#(
  parameter int PULSE_CYCLES = 3
) (
  input wire logic       clock_in,
  input wire logic       reset_in,
  input wire host_req_t  host_in,
  input wire mcu_req_t   mcu_in,
  input wire logic       input_full_irq_en_in,
  input wire logic [7:0] fast_reset_gate_cfg_in,
  input wire logic       kbc_gate_port_bit_in,
  input wire logic [7:0] host_rdata_out,
  input wire logic       host_claim_out,
  input wire logic [7:0] mcu_status_out,
  input wire logic       input_full_irq_n_out,
  input wire logic       aux_interrupt_out,
  input wire logic       alt_gate_line_out,
  input wire logic       alt_cpu_reset_n_out,
  input wire logic       cpu_addr20_mask_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  wire logic cmd_wr = host_in.wr && host_in.addr == `KBC_CMD_ADDR;
  wire logic dat_wr = host_in.wr && host_in.addr == `KBC_DATA_ADDR;
  wire logic fst_rd = host_in.rd && host_in.addr == `FAST_PORT_ADDR;
  logic [7:0] low_cnt;
  // ====
  // counts cycles of the alternate reset pulse
  always_ff @(posedge clock_in) begin
    if (reset_in || alt_cpu_reset_n_out)
      low_cnt <= 8'h00;
    else
      low_cnt <= low_cnt + 8'h01;
  end
  cmd_write_a: assert property (cmd_wr |-> ##2 mcu_status_out[3] && mcu_status_out[1])
    else $error("command write flags wrong");
  data_write_a: assert property (dat_wr |-> ##2 !mcu_status_out[3] && mcu_status_out[1])
    else $error("data write flags wrong");
  in_clear_a: assert property (mcu_in.in_buf_rd && !cmd_wr && !dat_wr |-> ##2 !mcu_status_out[1])
    else $error("input full not cleared");
  out_set_a: assert property (mcu_in.out_buf_wr |-> ##2 mcu_status_out[0])
    else $error("output full not set");
  irq_pair_a: assert property (input_full_irq_n_out != aux_interrupt_out)
    else $error("interrupt outputs disagree");
  irq_follow_a: assert property (
    aux_interrupt_out == ($past(input_full_irq_en_in) && mcu_status_out[1]))
    else $error("interrupt does not follow enable and input full");
  fast_off_a: assert property (fst_rd && !fast_reset_gate_cfg_in[2] |=> !host_claim_out)
    else $error("disabled port claimed a read");
  fast_read_a: assert property (fst_rd && fast_reset_gate_cfg_in[2] |=>
    host_claim_out && host_rdata_out[7:2] == 6'h09)
    else $error("fast port read wrong");
  pulse_width_a: assert property ($rose(alt_cpu_reset_n_out) |-> low_cnt == PULSE_CYCLES)
    else $error("alternate reset width wrong");
  pulse_bound_a: assert property (!alt_cpu_reset_n_out |-> low_cnt < PULSE_CYCLES)
    else $error("alternate reset too long");
  mask_low_a: assert property ((!kbc_gate_port_bit_in && !alt_gate_line_out)[*3] |->
    !cpu_addr20_mask_n_out)
    else $error("address mask not low");
  mask_high_a: assert property ((kbc_gate_port_bit_in || alt_gate_line_out)[*3] |->
    cpu_addr20_mask_n_out)
    else $error("address mask not high");
  cover property ($rose(alt_cpu_reset_n_out));
  cover property (cmd_wr);
  cover property (fst_rd && host_claim_out);
endmodule
bind kbc_status_fast_gate_reset kbc_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) kbc_monitor_inst (
  .clock_in, .reset_in, .host_in, .mcu_in, .input_full_irq_en_in,
  .fast_reset_gate_cfg_in, .kbc_gate_port_bit_in,
  .host_rdata_out, .host_claim_out, .mcu_status_out, .input_full_irq_n_out, .aux_interrupt_out,
  .alt_gate_line_out, .alt_cpu_reset_n_out, .cpu_addr20_mask_n_out);
`default_nettype wire

// ==== kbc_pkg.sv ====
// types shared by the keyboard-controller status and fast gate/reset block
`default_nettype none
package kbc_pkg;

  // one host i/o cycle
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } host_req_t;

  // one microcontroller access
  typedef struct packed {
    logic       status_wr;
    logic [7:0] status_wdata;
    logic       out_buf_wr;
    logic [7:0] out_buf_wdata;
    logic       in_buf_rd;
  } mcu_req_t;

  // alternate reset sequencer states
  typedef enum logic [1:0] {
    alt_idle,
    alt_delay,
    alt_pulse,
    alt_spent
  } alt_state_t;

endpackage
`default_nettype wire

// ==== kbc_status_fast_gate_reset.sv ====
// keyboard-controller host status flags with fast gate and reset port
//
// Overview of operation
// R1: status byte holds command flag bit 3, input full bit 1, output full bit 0.
// R2: status byte clears to zero on system reset.
// R3: host reads status only; microcontroller reads and writes it.
// R4: host input write loads command flag from host address bit 2.
// R5: host input write sets input full, raising the enabled input interrupt.
// R6: microcontroller input read clears input full and its interrupt.
// R7: microcontroller output write sets output full; host output read clears it.
// R8: supplied reset lasts at least 24 reference clock periods.
// R9: fast port at 92h answers only while enable bit 2 is set.
// R10: fast port resets to 24h; reserved bits read fixed 00,1,0,0,1.
// R11: fast port bit 1 sets the alternate gate level directly.
// R12: writing bit 0 as 1 pulses alternate reset low after a delay.
// R13: one pulse per arming; bit 0 must return to 0 first.
// R14: system reset clears bit 0, leaving alternate reset high.
// R15: alternate reset is ANDed with controller reset, polarity selectable.
// R16: address-20 mask low only when gate port bit and alternate gate low.
// R17: system reset drives the alternate gate low.
// R18: data address write clears command flag; command address write sets it.
// R19: disabled fast port ignores writes and does not claim reads.
`default_nettype none
`include "kbc_consts.svh"
module kbc_status_fast_gate_reset
  import kbc_pkg::*;
#(
  parameter int DELAY_CYCLES = `ALT_DELAY_CYCLES,
  parameter int PULSE_CYCLES = `ALT_PULSE_CYCLES
) (
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  input  wire host_req_t  host_in,
  input  wire mcu_req_t   mcu_in,
  input  wire logic       input_full_irq_en_in,
  input  wire logic [7:0] fast_reset_gate_cfg_in,
  input  wire logic       kbc_gate_port_bit_in,
  input  wire logic       kbc_reset_n_in,
  input  wire logic       reset_polarity_in,
  output var  logic [7:0] host_rdata_out,
  output var  logic       host_claim_out,
  output var  logic [7:0] mcu_status_out,
  output var  logic [7:0] cpu_data_buffer_out,
  output var  logic [7:0] mcu_in_buf_out,
  output var  logic       input_full_irq_n_out,
  output var  logic       aux_interrupt_out,
  output var  logic       alt_gate_line_out,
  output var  logic       alt_cpu_reset_n_out,
  output var  logic       keyboard_reset_out,
  output var  logic       cpu_addr20_mask_n_out
);

  logic [7:0] status;
  logic [7:0] fast_port;
  logic       alt_rst_n;
  logic       host_in_wr;
  logic       host_out_rd;
  logic       fast_hit;
  logic       fast_en;

  // ==========================================
  // address decode
  function automatic logic is_addr(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction

  assign fast_en     = fast_reset_gate_cfg_in[`FAST_EN_POS];
  assign host_in_wr  = host_in.wr && (is_addr(host_in.addr, `KBC_DATA_ADDR)
                       || is_addr(host_in.addr, `KBC_CMD_ADDR));
  assign host_out_rd = host_in.rd && is_addr(host_in.addr, `KBC_DATA_ADDR);
  assign fast_hit    = fast_en && is_addr(host_in.addr, `FAST_PORT_ADDR); // R9 R19

  // ==========================================
  // status flags
  status_flags u_status (
    .clock_in       (clock_in),
    .reset_in       (reset_in),
    .host_in_wr_in  (host_in_wr),
    .host_cmd_in    (host_in.addr[`HOST_ADDR_BIT2_POS]), // R4
    .host_out_rd_in (host_out_rd),
    .mcu_in         (mcu_in),
    .status_out     (status)
  );

  // ==========================================
  // data buffers
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      cpu_data_buffer_out <= 8'h00;
      mcu_in_buf_out      <= 8'h00;
    end else begin
      if (mcu_in.out_buf_wr) begin
        cpu_data_buffer_out <= mcu_in.out_buf_wdata;
      end
      if (host_in_wr) begin
        mcu_in_buf_out <= host_in.wdata;
      end
    end
  end

  // ==========================================
  // fast port register, only bits 1:0 are storage
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      fast_port <= `FAST_RESET; // R10 R14 R17
    end else if (host_in.wr && fast_hit) begin // R9 R19
      fast_port <= (host_in.wdata & `FAST_READ_MASK) | `FAST_READ_FIXED; // R10
    end
  end

  // ==========================================
  // host read mux; status is read-only from the host side
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      host_rdata_out <= 8'h00;
      host_claim_out <= 1'b0;
    end else begin
      host_claim_out <= host_in.rd && (fast_hit // R19
                        || is_addr(host_in.addr, `KBC_DATA_ADDR)
                        || is_addr(host_in.addr, `KBC_CMD_ADDR));
      if (host_in.rd && fast_hit) begin
        host_rdata_out <= (fast_port & `FAST_READ_MASK) | `FAST_READ_FIXED; // R10
      end else if (host_in.rd && is_addr(host_in.addr, `KBC_CMD_ADDR)) begin
        host_rdata_out <= status; // R1 R3 R18
      end else if (host_out_rd) begin
        host_rdata_out <= cpu_data_buffer_out; // R7
      end else begin
        host_rdata_out <= 8'h00;
      end
    end
  end

  // ==========================================
  // alternate reset one-shot
  alt_reset_pulser #(
    .DELAY_CYCLES (DELAY_CYCLES),
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_pulser (
    .clock_in            (clock_in),
    .reset_in            (reset_in),
    .arm_in              (fast_port[`FAST_RST_POS]), // R13
    .alt_cpu_reset_n_out (alt_rst_n)
  );

  // ==========================================
  // registered outputs
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      mcu_status_out        <= `STAT_RESET;
      input_full_irq_n_out  <= 1'b1;
      aux_interrupt_out     <= 1'b0;
      alt_gate_line_out     <= 1'b0; // R17
      alt_cpu_reset_n_out   <= 1'b1; // R14
      keyboard_reset_out    <= 1'b0;
      cpu_addr20_mask_n_out <= 1'b0;
    end else begin
      mcu_status_out        <= status;
      input_full_irq_n_out  <= !(input_full_irq_en_in && status[`STAT_IN_FULL_POS]); // R5 R6
      aux_interrupt_out     <= input_full_irq_en_in && status[`STAT_IN_FULL_POS]; // R5 R6
      alt_gate_line_out     <= fast_port[`FAST_GATE_POS]; // R11
      alt_cpu_reset_n_out   <= alt_rst_n; // R12
      keyboard_reset_out    <= (alt_rst_n && kbc_reset_n_in) ^ reset_polarity_in; // R15
      cpu_addr20_mask_n_out <= kbc_gate_port_bit_in || fast_port[`FAST_GATE_POS]; // R16
    end
  end

endmodule
`default_nettype wire

// ==== kbc_status_fast_gate_reset_test.sv ====
// self-checking bench for the status flags and fast gate/reset port
`default_nettype none
`include "kbc_consts.svh"
module kbc_status_fast_gate_reset_test
  import kbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DLY = 4;
  localparam int PLS = 3;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  host_req_t host_in;
  mcu_req_t mcu_in = '0;
  logic input_full_irq_en_in = 1'b1;
  logic [7:0] fast_reset_gate_cfg_in = 8'h04;
  logic kbc_gate_port_bit_in = 1'b0;
  logic kbc_reset_n_in = 1'b1;
  logic reset_polarity_in = 1'b0;
  logic [7:0] host_rdata_out, mcu_status_out, cpu_data_buffer_out, mcu_in_buf_out, r;
  logic host_claim_out, input_full_irq_n_out, aux_interrupt_out, alt_gate_line_out;
  logic alt_cpu_reset_n_out, keyboard_reset_out, cpu_addr20_mask_n_out;
  int miscompares = 0;
  int n_checks = 0;
  int lo_a, lo_k;
  logic [7:0] exp_q[$];
  always #20 clock_in = ~clock_in;
  kbc_status_fast_gate_reset #(.DELAY_CYCLES(DLY), .PULSE_CYCLES(PLS))
    kbc_status_fast_gate_reset_inst (.clock_in, .reset_in, .host_in, .mcu_in,
    .input_full_irq_en_in, .fast_reset_gate_cfg_in, .kbc_gate_port_bit_in, .kbc_reset_n_in,
    .reset_polarity_in, .host_rdata_out, .host_claim_out, .mcu_status_out, .cpu_data_buffer_out,
    .mcu_in_buf_out, .input_full_irq_n_out, .aux_interrupt_out, .alt_gate_line_out,
    .alt_cpu_reset_n_out, .keyboard_reset_out, .cpu_addr20_mask_n_out);
  host_model host_model_inst (.clock_in, .host_out(host_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_model_inst.io(1'b1, a, 8'h00);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host_model_inst.io(1'b0, a, d);
  endtask
  task automatic mc(input mcu_req_t m);
    @(negedge clock_in);
    mcu_in <= m;
    @(negedge clock_in);
    mcu_in <= '0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  // counts low cycles of both reset outputs over one arming window
  task automatic pulse(input int e);
    lo_a = 0;
    lo_k = 0;
    repeat (DLY + PLS + 8) begin
      @(negedge clock_in);
      lo_a += !alt_cpu_reset_n_out;
      lo_k += !keyboard_reset_out;
    end
    check(lo_a[7:0], e[7:0]);
    check(lo_k[7:0], e[7:0]);
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ====
  // compares each claimed read with the oldest note
  always @(negedge clock_in) begin
    if (host_claim_out === 1'b1) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("[FAIL] %0t ns: read claimed with nothing expected", $time);
      end
      else
        check(host_rdata_out, exp_q.pop_front());
    end
  end
  initial begin
    #(40 * 3000);
    miscompares++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h296ece87));
    r = 8'($urandom);
    idle(4);
    reset_in <= 1'b0;
    rd(`KBC_CMD_ADDR, 8'h00);
    rd(`FAST_PORT_ADDR, 8'h24);
    check(alt_gate_line_out, 1'b0);
    check(alt_cpu_reset_n_out, 1'b1);
    check(cpu_addr20_mask_n_out, 1'b0);
    $display("reset values done");
    wr(`KBC_CMD_ADDR, r);
    idle(2);
    rd(`KBC_CMD_ADDR, 8'h0a);
    check(input_full_irq_n_out, 1'b0);
    check(aux_interrupt_out, 1'b1);
    check(mcu_in_buf_out, r);
    mc('{1'b0, 8'h00, 1'b0, 8'h00, 1'b1});
    idle(2);
    check(input_full_irq_n_out, 1'b1);
    input_full_irq_en_in <= 1'b0;
    wr(`KBC_DATA_ADDR, ~r);
    idle(2);
    check(input_full_irq_n_out, 1'b1);
    check(aux_interrupt_out, 1'b0);
    check(mcu_in_buf_out, ~r);
    input_full_irq_en_in <= 1'b1;
    idle(2);
    check(input_full_irq_n_out, 1'b0);
    rd(`KBC_CMD_ADDR, 8'h02);
    $display("input flags done");
    mc('{1'b1, r, 1'b0, 8'h00, 1'b0});
    rd(`KBC_CMD_ADDR, r);
    mc('{1'b1, 8'h00, 1'b1, ~r, 1'b0});
    check(cpu_data_buffer_out, ~r);
    rd(`KBC_CMD_ADDR, 8'h01);
    rd(`KBC_DATA_ADDR, ~r);
    rd(`KBC_CMD_ADDR, 8'h00);
    $display("output flag done");
    wr(`FAST_PORT_ADDR, 8'hfe);
    idle(2);
    check(alt_gate_line_out, 1'b1);
    rd(`FAST_PORT_ADDR, 8'h26);
    wr(`FAST_PORT_ADDR, 8'h00);
    kbc_gate_port_bit_in <= 1'b1;
    idle(3);
    check(cpu_addr20_mask_n_out, 1'b1);
    kbc_gate_port_bit_in <= 1'b0;
    fast_reset_gate_cfg_in <= 8'h00;
    wr(`FAST_PORT_ADDR, 8'h03);
    host_model_inst.io(1'b1, `FAST_PORT_ADDR, 8'h00);
    pulse(0);
    check(alt_gate_line_out, 1'b0);
    $display("gate and disable done");
    fast_reset_gate_cfg_in <= 8'h04;
    wr(`FAST_PORT_ADDR, 8'h01);
    pulse(PLS);
    wr(`FAST_PORT_ADDR, 8'h01);
    pulse(0);
    wr(`FAST_PORT_ADDR, 8'h00);
    wr(`FAST_PORT_ADDR, 8'h01);
    pulse(PLS);
    kbc_reset_n_in <= 1'b0;
    idle(3);
    check(keyboard_reset_out, 1'b0);
    reset_polarity_in <= 1'b1;
    idle(3);
    check(keyboard_reset_out, 1'b1);
    reset_polarity_in <= 1'b0;
    kbc_reset_n_in <= 1'b1;
    $display("alternate reset done");
    wr(`FAST_PORT_ADDR, 8'h03);
    reset_in <= 1'b1;
    idle(4);
    reset_in <= 1'b0;
    check(alt_gate_line_out, 1'b0);
    rd(`FAST_PORT_ADDR, 8'h24);
    pulse(0);
    check(8'(exp_q.size()), 8'h00);
    $display("mid-run reset done");
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== status_flags.sv ====
// host status flags: command/data, input full and output full
`default_nettype none
`include "kbc_consts.svh"
module status_flags
  import kbc_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  input  wire logic       host_in_wr_in,
  input  wire logic       host_cmd_in,
  input  wire logic       host_out_rd_in,
  input  wire mcu_req_t   mcu_in,
  output var  logic [7:0] status_out
);

  logic [7:0] next_status;

  // ==========================================
  // user bits are software-owned; hardware flags have set priority
  always_comb begin
    next_status = status_out;
    if (mcu_in.status_wr) begin
      next_status = mcu_in.status_wdata; // R3
    end
    if (mcu_in.in_buf_rd) begin
      next_status[`STAT_IN_FULL_POS] = 1'b0; // R6
    end
    if (host_out_rd_in) begin
      next_status[`STAT_OUT_FULL_POS] = 1'b0; // R7
    end
    if (host_in_wr_in) begin
      next_status[`STAT_IN_FULL_POS] = 1'b1; // R5
      next_status[`STAT_CMD_POS]     = host_cmd_in; // R4 R18
    end
    if (mcu_in.out_buf_wr) begin
      next_status[`STAT_OUT_FULL_POS] = 1'b1; // R7
    end
  end

  // status register, cleared by system reset
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      status_out <= `STAT_RESET; // R2
    end else begin
      status_out <= next_status;
    end
  end

endmodule
`default_nettype wire
